// ==== src/emw_pkg.sv ====
// emw_pkg: constants, field layouts and carrier types for the external memory
// interface controller with page-based wait states.
// assumes: shared by emw_ext_mem and emw_wait_sel; no timescale in packages.
package emw_pkg;

   // ==========================================================================
   // register indices (byte address is four times the index)
   localparam logic [7:0] EMW_IDX_MCU_CONTROL = 8'h35;
   localparam logic [7:0] EMW_IDX_EXT_CONTROL = 8'h36;
   localparam logic [7:0] EMW_IDX_STATUS = 8'h37;

   // ==========================================================================
   // reset values
   localparam logic [7:0] EMW_MCU_CONTROL_RST = 8'h00;
   localparam logic [7:0] EMW_EXT_CONTROL_RST = 8'h00;

   // ==========================================================================
   // field positions
   localparam int EMW_BIT_ENABLE = 7;        // mcu_control: ext_mem_enable
   localparam int EMW_BIT_UPPER_WAIT_LO = 6; // mcu_control: upper_wait_lo
   localparam int EMW_BIT_LIMIT_B2 = 6;      // extended_mcu_control: page_limit_b2
   localparam int EMW_BIT_LIMIT_B1 = 5;
   localparam int EMW_BIT_LIMIT_B0 = 4;
   localparam int EMW_BIT_LOWER_WAIT_HI = 3; // extended_mcu_control
   localparam int EMW_BIT_LOWER_WAIT_LO = 2;
   localparam int EMW_BIT_UPPER_WAIT_HI = 1;

   // status register bit positions
   localparam int EMW_ST_BUSY = 0;
   localparam int EMW_ST_UPPER = 1;
   localparam int EMW_ST_EXTRA_LSB = 2;
   localparam int EMW_ST_GAP = 4;

   // ==========================================================================
   // address map and wait codes
   localparam logic [15:0] EMW_LOWER_PAGE_START = 16'h0460;
   localparam logic [1:0] EMW_WAIT_NONE = 2'h0;
   localparam logic [1:0] EMW_WAIT_ONE = 2'h1;
   localparam logic [1:0] EMW_WAIT_TWO = 2'h2;
   localparam logic [1:0] EMW_WAIT_TWO_GAP = 2'h3;

   // ==========================================================================
   // carriers
   typedef struct packed {
      logic [7:0] ad_out;    // muxed_addr_data drive value
      logic [7:0] ad_oe_n;   // low while driven
      logic [7:0] hi_out;    // high_addr drive value
      logic [7:0] hi_oe_n;
      logic ale;             // address latch strobe
      logic ale_oe_n;
      logic rd_n;
      logic rd_oe_n;
      logic wr_n;
      logic wr_oe_n;
   } emw_pins_t;

   typedef struct packed {
      logic [7:0] a_out;     // ordinary port values and directions (1 = output)
      logic [7:0] a_dir;
      logic [7:0] c_out;
      logic [7:0] c_dir;
      logic ale_out;
      logic ale_dir;
      logic rd_out;
      logic rd_dir;
      logic wr_out;
      logic wr_dir;
   } emw_gpio_t;

   typedef struct packed {
      logic ext;             // address lies in external space
      logic upper;           // access falls in the upper page
      logic [1:0] extra;     // strobe extension in cycles
      logic gap;             // one idle cycle before next address
   } emw_wait_t;

   // byte address of a register index
   function automatic logic [9:0] emw_byte_addr(input logic [7:0] idx);
      return {idx, 2'b00};
   endfunction

   // start of the upper page for a nonzero limit code
   function automatic logic [15:0] emw_upper_start(input logic [2:0] code);
      return {code, 13'h0000};
   endfunction

endpackage

// ==== src/emw_wait_sel.sv ====
// emw_wait_sel: picks page and wait-state timing for one data address.
// assumes: register images come straight from the register file; purely combinational.
`timescale 1ns/1ps
module emw_wait_sel
   import emw_pkg::*;
(
   // configuration
   input wire logic [7:0] mcu_control,
   input wire logic [7:0] ext_control,
   // address under decode
   input wire logic [15:0] addr,
   // result
   output emw_wait_t sel
);

   logic [2:0] limit;
   logic [1:0] code;

   // ==========================================================================
   // page split and code selection
   always_comb
   begin
      limit = {ext_control[EMW_BIT_LIMIT_B2], ext_control[EMW_BIT_LIMIT_B1], ext_control[EMW_BIT_LIMIT_B0]};
      sel.ext = mcu_control[EMW_BIT_ENABLE] && (addr >= EMW_LOWER_PAGE_START);
      // limit zero makes one page timed by the upper bits
      sel.upper = (limit == 3'h0) || (addr >= emw_upper_start(limit));
      if (sel.upper)
      begin
         code = {ext_control[EMW_BIT_UPPER_WAIT_HI], mcu_control[EMW_BIT_UPPER_WAIT_LO]};
      end
      else
      begin
         code = {ext_control[EMW_BIT_LOWER_WAIT_HI], ext_control[EMW_BIT_LOWER_WAIT_LO]};
      end
      // code 11 stretches like 10 and adds the address gap
      case (code)
         EMW_WAIT_NONE: sel.extra = 2'h0;
         EMW_WAIT_ONE: sel.extra = 2'h1;
         EMW_WAIT_TWO: sel.extra = 2'h2;
         default: sel.extra = 2'h2;
      endcase
      sel.gap = (code == EMW_WAIT_TWO_GAP);
   end

endmodule // emw_wait_sel

// ==== src/emw_ext_mem.sv ====
// emw_ext_mem: external data-memory interface controller with two wait-state pages,
// apb register file, core access port and pin multiplexing.
// assumes: one 50 MHz clock, async active-low reset, core inputs synchronous to clk.
//
// What this block does
// - enable bit hands pins to memory interface
// - enable clear keeps ordinary pin values, directions
// - two pages, each with own wait code
// - limit zero: one page, upper wait bits
// - upper code: ext bit1 high, main bit6 low
// - lower code: ext bits 3..2
// - codes 00/01/10/11 give 0/1/2/2+gap waits
// - lower from 0460, upper from code times 2000
// - latch pulse only when next access uses memory
// - address and data change only with latch pulse
// - address valid at latch fall, latch low during transfer
// - read/write strobes only for external accesses
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
module emw_ext_mem
   import emw_pkg::*;
#(
   parameter int APB_AW = 12
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [APB_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // core data-memory access port
   input wire logic core_req,
   input wire logic core_we,
   input wire logic [15:0] core_addr,
   input wire logic [7:0] core_wdata,
   output logic core_ready,
   output logic core_done,
   output logic core_internal,
   output logic [7:0] core_rdata,
   // ordinary port settings and pins
   input wire emw_gpio_t gpio,
   input wire logic [7:0] ad_in,
   output emw_pins_t pins
);

   typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_STROBE, ST_GAP} emw_state_t;

   // ==========================================================================
   // declarations
   emw_state_t state_reg;
   logic [7:0] mcu_control_reg;
   logic [7:0] ext_control_reg;
   logic [15:0] addr_reg;
   logic [7:0] wdata_reg;
   logic we_reg;
   emw_wait_t sel_reg;
   emw_wait_t sel_now;
   logic [1:0] count_reg;
   logic [7:0] ad_out_reg;
   logic [7:0] hi_out_reg;
   logic ad_drive_reg;
   logic ale_reg;
   logic rd_n_reg;
   logic wr_n_reg;
   logic [7:0] rdata_reg;
   logic done_reg;
   logic internal_reg;
   logic [7:0] status_word;
   logic enable;
   logic take;
   logic take_ext;
   logic strobe_last;
   logic apb_access;
   logic apb_write;
   logic hit_mcu;
   logic hit_ext;
   logic hit_status;

   assign enable = mcu_control_reg[EMW_BIT_ENABLE];

   // ==========================================================================
   // wait-state selection for the address on offer
   emw_wait_sel u_wait_sel (
      .mcu_control(mcu_control_reg),
      .ext_control(ext_control_reg),
      .addr(core_addr),
      .sel(sel_now)
   );

   // ==========================================================================
   // apb decode; always ready, so every transfer ends in its first access cycle
   assign apb_access = psel && penable;
   assign apb_write = apb_access && pwrite && pstrb[0];
   assign hit_mcu = (paddr == APB_AW'(emw_byte_addr(EMW_IDX_MCU_CONTROL)));
   assign hit_ext = (paddr == APB_AW'(emw_byte_addr(EMW_IDX_EXT_CONTROL)));
   assign hit_status = (paddr == APB_AW'(emw_byte_addr(EMW_IDX_STATUS)));
   assign pready = 1'b1;
   assign pslverr = apb_access && !(hit_mcu || hit_ext || hit_status);

   // status shows the engine's own state
   always_comb
   begin
      status_word = 8'h00;
      status_word[EMW_ST_BUSY] = (state_reg != ST_IDLE);
      status_word[EMW_ST_UPPER] = sel_reg.upper;
      status_word[EMW_ST_EXTRA_LSB +: 2] = sel_reg.extra;
      status_word[EMW_ST_GAP] = sel_reg.gap;
   end

   // read mux; narrow registers sit in the low byte, unmapped reads as zero
   always_comb
   begin
      prdata = 32'h0000_0000;
      if (hit_mcu)
      begin
         prdata = {24'h00_0000, mcu_control_reg};
      end
      else if (hit_ext)
      begin
         prdata = {24'h00_0000, ext_control_reg};
      end
      else if (hit_status)
      begin
         prdata = {24'h00_0000, status_word};
      end
   end

   // ==========================================================================
   // configuration registers; the status word ignores writes
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mcu_control_reg <= EMW_MCU_CONTROL_RST;
         ext_control_reg <= EMW_EXT_CONTROL_RST;
      end
      else if (apb_write && hit_mcu)
      begin
         mcu_control_reg <= pwdata[7:0];
      end
      else if (apb_write && hit_ext)
      begin
         ext_control_reg <= pwdata[7:0];
      end
   end

   // ==========================================================================
   // request acceptance: only in idle, so a gap cycle stalls the core
   assign core_ready = (state_reg == ST_IDLE);
   assign take = core_ready && core_req;
   assign take_ext = take && sel_now.ext;
   assign strobe_last = (state_reg == ST_STROBE) && (count_reg == 2'h0);

   // ==========================================================================
   // access sequencer: addr (latch high) -> strobe (1 + extra cycles) -> gap?
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg <= ST_IDLE;
         count_reg <= 2'h0;
      end
      else
      begin
         case (state_reg)
            ST_IDLE:
            begin
               if (take_ext)
               begin
                  state_reg <= ST_ADDR;
               end
            end
            ST_ADDR:
            begin
               state_reg <= ST_STROBE;
               count_reg <= sel_reg.extra;
            end
            ST_STROBE:
            begin
               if (count_reg != 2'h0)
               begin
                  count_reg <= count_reg - 2'h1;
               end
               else if (sel_reg.gap)
               begin
                  state_reg <= ST_GAP;
               end
               else
               begin
                  state_reg <= ST_IDLE;
               end
            end
            ST_GAP:
            begin
               state_reg <= ST_IDLE;
            end
            default:
            begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // ==========================================================================
   // request capture; held through the whole access
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         addr_reg <= 16'h0000;
         wdata_reg <= 8'h00;
         we_reg <= 1'b0;
         sel_reg <= '0;
      end
      else if (take_ext)
      begin
         addr_reg <= core_addr;
         wdata_reg <= core_wdata;
         we_reg <= core_we;
         sel_reg <= sel_now;
      end
   end

   // ==========================================================================
   // address latch strobe: one pulse per external access, low for the transfer
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ale_reg <= 1'b0;
      end
      else
      begin
         // pulses only when a memory access follows, never on idle cycles
         ale_reg <= take_ext;
      end
   end

   // ==========================================================================
   // address and data drive; values change when an address is taken and again at the latch fall
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ad_out_reg <= 8'h00;
         hi_out_reg <= 8'h00;
         ad_drive_reg <= 1'b0;
      end
      else if (take_ext)
      begin
         ad_out_reg <= core_addr[7:0];
         hi_out_reg <= core_addr[15:8];
         ad_drive_reg <= 1'b1;
      end
      else if (state_reg == ST_ADDR)
      begin
         // at the latch fall the low byte has been stable for a full cycle
         ad_out_reg <= we_reg ? wdata_reg : ad_out_reg;
         ad_drive_reg <= we_reg; // release the port for read data
      end
   end

   // ==========================================================================
   // read and write strobes, external accesses only
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rd_n_reg <= 1'b1;
         wr_n_reg <= 1'b1;
      end
      else if (state_reg == ST_ADDR)
      begin
         rd_n_reg <= we_reg;
         wr_n_reg <= !we_reg;
      end
      else if (strobe_last)
      begin
         rd_n_reg <= 1'b1;
         wr_n_reg <= 1'b1;
      end
   end

   // ==========================================================================
   // completion toward the core; internal space answers at once
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         done_reg <= 1'b0;
         internal_reg <= 1'b0;
         rdata_reg <= 8'h00;
      end
      else
      begin
         // internal accesses never touch the strobes or the pins
         internal_reg <= take && !sel_now.ext;
         done_reg <= (take && !sel_now.ext) || strobe_last;
         if (strobe_last && !we_reg)
         begin
            rdata_reg <= ad_in; // sampled in the last strobe cycle
         end
      end
   end

   assign core_done = done_reg;
   assign core_internal = internal_reg;
   assign core_rdata = rdata_reg;

   // ==========================================================================
   // pin multiplexing: enable overrides direction settings
   always_comb
   begin
      if (enable)
      begin
         pins.ad_out = ad_out_reg;
         pins.ad_oe_n = {8{!ad_drive_reg}};
         pins.hi_out = hi_out_reg;
         pins.hi_oe_n = 8'h00;
         pins.ale = ale_reg;
         pins.ale_oe_n = 1'b0;
         pins.rd_n = rd_n_reg;
         pins.rd_oe_n = 1'b0;
         pins.wr_n = wr_n_reg;
         pins.wr_oe_n = 1'b0;
      end
      else
      begin
         // interface disabled: ordinary values and directions pass through
         pins.ad_out = gpio.a_out;
         pins.ad_oe_n = ~gpio.a_dir;
         pins.hi_out = gpio.c_out;
         pins.hi_oe_n = ~gpio.c_dir;
         pins.ale = gpio.ale_out;
         pins.ale_oe_n = !gpio.ale_dir;
         pins.rd_n = gpio.rd_out;
         pins.rd_oe_n = !gpio.rd_dir;
         pins.wr_n = gpio.wr_out;
         pins.wr_oe_n = !gpio.wr_dir;
      end
   end

endmodule // emw_ext_mem

// ==== sim/emw_ext_mem_assertions.sv ====
// emw_ext_mem_assertions: pin and core-port timing checks.
// assumes: bound into emw_ext_mem; bench keeps gpio.ale_dir low.
`timescale 1ns/1ps
module emw_ext_mem_assertions
   import emw_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // core port
   input wire logic core_req,
   input wire logic core_ready,
   input wire logic [15:0] core_addr,
   input wire logic core_done,
   input wire logic core_internal,
   // pins
   input wire emw_gpio_t gpio,
   input wire emw_pins_t pins
);
   // ==========================================================
   // shared terms
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // either strobe active
   logic strobe;
   assign strobe = !pins.rd_n || !pins.wr_n;
   sequence s_take_int;
      core_req && core_ready && core_addr < EMW_LOWER_PAGE_START;
   endsequence
   sequence s_latch;
      pins.ale && !pins.ale_oe_n;
   endsequence
   // ==========================================================
   // ownership: ale_oe_n low stands for enable, since gpio keeps ale as input
   // the muxed port must be released while read data comes in, and driven while writing
   a_iface_owns: assert property (!pins.ale_oe_n |-> !pins.hi_oe_n && !pins.rd_oe_n && !pins.wr_oe_n
      && (pins.rd_n || pins.ad_oe_n == 8'hff) && (pins.wr_n || pins.ad_oe_n == 8'h00))
      else $error("pins not owned while enabled");
   a_gpio_through: assert property (pins.ale_oe_n |-> pins.ad_out == gpio.a_out
      && pins.ad_oe_n == ~gpio.a_dir && pins.hi_out == gpio.c_out)
      else $error("ordinary port values not passed");
   // ==========================================================
   // access sequencing
   a_latch_addr: assert property (s_latch |-> !pins.ad_oe_n && {pins.hi_out, pins.ad_out} == $past(core_addr))
      else $error("address wrong at latch");
   a_latch_on_take: assert property (s_latch |-> $past(core_req) && $past(core_ready))
      else $error("latch pulse without a taken access");
   a_latch_strobe: assert property (s_latch |=> !pins.ale && strobe)
      else $error("strobe does not follow latch");
   a_no_latch_in: assert property (strobe && !pins.ale_oe_n |-> !pins.ale)
      else $error("latch high during strobe");
   a_internal_quiet: assert property (s_take_int |=> core_done && core_internal && !strobe)
      else $error("internal access misbehaves");
   a_strobe_bound: assert property ($rose(strobe) |-> ##[1:3] !strobe)
      else $error("strobe too long");
   a_done_at_end: assert property ($fell(strobe) |-> core_done)
      else $error("done not at strobe end");
   a_addr_hold: assert property (!pins.ale && !pins.ale_oe_n && !$past(pins.ale_oe_n) |-> $stable(pins.hi_out))
      else $error("address moved without latch");
   a_gap_short: assert property (core_done && !core_internal |-> ##[0:1] core_ready)
      else $error("gap longer than one cycle");
endmodule // emw_ext_mem_assertions

bind emw_ext_mem emw_ext_mem_assertions i_chk (.clk(clk), .rst_n(rst_n), .core_req(core_req),
   .core_ready(core_ready), .core_addr(core_addr), .core_done(core_done),
   .core_internal(core_internal), .gpio(gpio), .pins(pins));

// ==== sim/emw_sram_model.sv ====
// emw_sram_model: byte-wide external ram behind a transparent address latch.
// assumes: pins of emw_ext_mem; the muxed port has pull-ups when undriven.
`timescale 1ns/1ps
module emw_sram_model
   import emw_pkg::*;
(
   // clock
   input wire logic clk,
   // device pins
   input wire emw_pins_t pins,
   // level on the muxed port
   output logic [7:0] ad_in
);
   // ==========================================================
   // storage and low address latch
   logic [7:0] mem [0:65535];
   logic [7:0] lo;
   // latch is open while the strobe is high
   always_latch
   begin
      if (pins.ale)
         lo <= pins.ad_out;
   end
   // data taken only while the write strobe is low
   always @(posedge clk)
   begin
      if (!pins.wr_n && !pins.ad_oe_n)
         mem[{pins.hi_out, lo}] <= pins.ad_out;
   end
   // drive only during read strobe; if the controller does not drive either, the pull-ups win
   assign ad_in = !pins.ad_oe_n ? pins.ad_out : !pins.rd_n ? mem[{pins.hi_out, lo}] : 8'hff;
endmodule // emw_sram_model

// ==== sim/ext_memory_interface_waitstates_tb.sv ====
// ext_memory_interface_waitstates_tb: registers, wait codes and pages via apb and core port.
// assumes: emw_sram_model on the pins, 50 MHz clock.
`timescale 1ns/1ps
module ext_memory_interface_waitstates_tb;
   import emw_pkg::*;
   // ==========================================================
   // signals
   logic clk, rst_n, psel, penable, pwrite, pready, pslverr, er, gap_rdy;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb;
   logic core_req, core_we, core_ready, core_done, core_internal;
   logic [15:0] core_addr;
   logic [7:0] core_wdata, core_rdata, ad_in;
   emw_gpio_t gpio;
   emw_pins_t pins;
   int fail_count = 0;
   int check_count = 0;
   int lat, stb, ex;
   localparam logic [11:0] A_MCU = {2'h0, EMW_IDX_MCU_CONTROL, 2'h0};
   localparam logic [11:0] A_EXT = {2'h0, EMW_IDX_EXT_CONTROL, 2'h0};
   localparam logic [11:0] A_ST = {2'h0, EMW_IDX_STATUS, 2'h0};
   // status after an upper-page access with code 11: two extra cycles and the gap
   localparam logic [31:0] ST_LAST = 32'((1 << EMW_ST_UPPER) | (2 << EMW_ST_EXTRA_LSB) | (1 << EMW_ST_GAP));
   // ==========================================================
   // design and far side
   emw_ext_mem #(.APB_AW(12)) i_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .core_req(core_req), .core_we(core_we), .core_addr(core_addr),
      .core_wdata(core_wdata), .core_ready(core_ready), .core_done(core_done),
      .core_internal(core_internal), .core_rdata(core_rdata), .gpio(gpio), .ad_in(ad_in), .pins(pins));
   emw_sram_model i_mem (.clk(clk), .pins(pins), .ad_in(ad_in));
   // clock
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // ==========================================================
   // tasks
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e)
      begin
         $display("BAD %s expected %h seen %h", n, e, g);
         fail_count++;
      end
   endtask
   // one apb transfer, idle edge after so strobes never double-assign
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   // one core access; counts cycles to done and strobe cycles
   task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
      core_req <= 1'b1;
      core_we <= w;
      core_addr <= a;
      core_wdata <= d;
      do @(posedge clk); while (core_ready !== 1'b1);
      core_req <= 1'b0;
      lat = 0;
      stb = 0;
      do
      begin
         @(posedge clk);
         lat++;
         if (pins.rd_n === 1'b0 || pins.wr_n === 1'b0)
            stb++;
      end
      while (core_done !== 1'b1);
      gap_rdy = core_ready;
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // watchdog: whole run needs well under a thousand cycles
   initial
   begin
      repeat (4000) @(posedge clk);
      fail_count++;
      test_done();
   end
   // ==========================================================
   // tests
   initial
   begin
      {psel, penable, pwrite, core_req, core_we} = '0;
      paddr = '0;
      pwdata = '0;
      pstrb = 4'h1;
      core_addr = '0;
      core_wdata = '0;
      gpio = {8'h5a, 8'h0f, 8'hc3, 8'hf0, 6'b001010};
      rst_n = 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      apb(0, A_MCU, 8'h00);
      chk("mcu_control", 32'h0, rd);
      apb(0, A_EXT, 8'h00);
      chk("ext_control", 32'h0, rd);
      apb(1, 12'h100, 8'hff);
      chk("unmapped_err", 32'h1, {31'h0, er});
      $display("test registers done");
      chk("ad_gpio", {24'h0, gpio.a_out}, {24'h0, pins.ad_out});
      acc(1, 16'h1234, 8'h11);
      chk("off_internal", 32'h1, {31'h0, core_internal});
      $display("test disabled done");
      for (int c = 0; c < 4; c++)
      begin
         ex = (c == 0) ? 0 : (c == 1) ? 1 : 2;
         apb(1, A_MCU, {1'b1, c[0], 6'h0});
         apb(1, A_EXT, {6'h0, c[1], 1'b0});
         acc(1, 16'h0460 + 16'(c), 8'ha0 + 8'(c));
         chk("latency", 3 + ex, lat);
         chk("strobe_len", 1 + ex, stb);
         chk("gap_ready", {31'h0, c != 3}, {31'h0, gap_rdy});
         acc(0, 16'h0460 + 16'(c), 8'h00);
         chk("rdata", 8'ha0 + c, {24'h0, core_rdata});
      end
      apb(0, A_ST, 8'h00);
      chk("status", ST_LAST, rd);
      // a write with no byte strobe must leave the register alone
      pstrb <= 4'h0;
      apb(1, A_MCU, 8'h00);
      pstrb <= 4'h1;
      apb(0, A_MCU, 8'h00);
      chk("mcu_rw", 32'hc0, rd);
      $display("test wait codes done");
      apb(1, A_MCU, 8'h80);
      for (int l = 1; l < 8; l++)
      begin
         apb(1, A_EXT, {1'b0, 3'(l), 4'h6});
         acc(1, {3'(l), 13'h0} - 16'h1, 8'h5a);
         chk("lower_page", 2, stb);
         acc(1, {3'(l), 13'h0}, 8'h5b);
         chk("upper_page", 3, stb);
      end
      acc(1, 16'h0460, 8'h00);
      chk("lower_start", 2, stb);
      acc(0, 16'h045f, 8'h00);
      chk("int_latency", 1, lat);
      chk("int_flag", 32'h1, {31'h0, core_internal});
      $display("test pages done");
      test_done();
   end
endmodule // ext_memory_interface_waitstates_tb
